/* rtl/fbod_host.sv */
// Purpose: host-side controller driving a parallel boot-sector flash by its pins
// Assumes: one request at a time; flash data input sampled synchronous to mclk
// Notes: unprotect mode only raises a level request; the elevated supply is outside
`timescale 1ns/1ps
`include "fbod_regs.svh"
module fbod_host #(
  parameter int RESET_HOLD_CYC = `FBOD_CYC_MIN(`FBOD_T_RP_NS),
  parameter int READY_CYC      = `FBOD_CYC_MIN(`FBOD_T_READY_NS),
  parameter int ACC_CYC        = `FBOD_CYC_MIN(`FBOD_T_ACC_NS),
  parameter int WP_CYC         = `FBOD_CYC_MIN(`FBOD_T_WP_NS),
  parameter int SETUP_CYC      = `FBOD_CYC_MIN(`FBOD_T_SETUP_NS)
) (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     req_valid,
  input  wire fbod_pkg::fbod_op_type    req_op,
  input  wire logic [`FBOD_ADDR_W-1:0]  req_addr,
  input  wire logic [7:0]               req_wdata,
  input  wire logic                     top_boot,
  input  wire logic                     unprotect_exit,
  output logic                          req_ready,
  output logic                          rsp_valid,
  output logic      [7:0]               rsp_rdata,
  output logic      [2:0]               rsp_sector,
  output logic                          aborted,
  output logic                          unprotect_active,
  output logic                          chip_sel_n,
  output logic                          out_gate_n,
  output logic                          wr_strobe_n,
  output logic                          hw_reset_n,
  output logic      [`FBOD_ADDR_W-1:0]  addr,
  output logic      [7:0]               data_out,
  output logic                          data_oe,
  input  wire logic [7:0]               data_in
);
  localparam int CNT_W = 16;
  fbod_pkg::fbod_state_type state;
  fbod_pkg::fbod_state_type next_state;
  logic [CNT_W-1:0] cnt;
  logic             cnt_done;
  logic             take;
  logic             busy_wr;
  assign cnt_done = (cnt == '0);
  assign take     = (state == fbod_pkg::ST_IDLE) && req_valid;
  always_comb begin
    next_state = state;
    case (state)
      fbod_pkg::ST_IDLE: begin
        if (req_valid) begin
          case (req_op)
            fbod_pkg::OP_READ:  next_state = fbod_pkg::ST_RD;
            fbod_pkg::OP_WRITE: next_state = fbod_pkg::ST_WR;
            fbod_pkg::OP_RESET: next_state = fbod_pkg::ST_RSET;
            default:            next_state = fbod_pkg::ST_UNPR;
          endcase
        end
      end
      fbod_pkg::ST_RSET:  if (cnt_done) next_state = fbod_pkg::ST_RECOV;
      fbod_pkg::ST_RD:    if (cnt_done) next_state = fbod_pkg::ST_IDLE;
      fbod_pkg::ST_WR:    if (cnt_done) next_state = fbod_pkg::ST_WHOLD;
      fbod_pkg::ST_WHOLD: if (cnt_done) next_state = fbod_pkg::ST_IDLE;
      fbod_pkg::ST_RECOV: if (cnt_done) next_state = fbod_pkg::ST_IDLE;
      fbod_pkg::ST_UNPR:  if (unprotect_exit) next_state = fbod_pkg::ST_RECOV;
      default:            next_state = fbod_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= fbod_pkg::ST_RSET;
    end else begin
      state <= next_state;
    end
  end
  // per-state dwell counter; loaded on entry
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt <= CNT_W'(RESET_HOLD_CYC - 1);
    end else if (state != next_state) begin
      case (next_state)
        fbod_pkg::ST_RSET:  cnt <= CNT_W'(RESET_HOLD_CYC - 1);
        fbod_pkg::ST_RD:    cnt <= CNT_W'(ACC_CYC);
        fbod_pkg::ST_WR:    cnt <= CNT_W'(WP_CYC - 1);
        fbod_pkg::ST_WHOLD: cnt <= CNT_W'(SETUP_CYC - 1);
        fbod_pkg::ST_RECOV: cnt <= CNT_W'(READY_CYC - 1);
        default:            cnt <= '0;
      endcase
    end else if (!cnt_done) begin
      cnt <= cnt - 1'b1;
    end
  end
  // pin levels per state; reset outranks all other pins
  always_ff @(posedge mclk) begin
    if (srst) begin
      chip_sel_n  <= 1'b1;
      out_gate_n  <= 1'b1;
      wr_strobe_n <= 1'b1;
      hw_reset_n  <= 1'b0;
    end else begin
      hw_reset_n  <= (next_state != fbod_pkg::ST_RSET);
      chip_sel_n  <= !(next_state == fbod_pkg::ST_RD ||
                       next_state == fbod_pkg::ST_WR);
      out_gate_n  <= (next_state != fbod_pkg::ST_RD);
      wr_strobe_n <= (next_state != fbod_pkg::ST_WR);
    end
  end
  // address held from request through the cycle; data driven from strobe low through the hold
  always_ff @(posedge mclk) begin
    if (srst) begin
      addr     <= '0;
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      if (take) begin
        addr     <= req_addr;
        data_out <= req_wdata;
      end
      data_oe <= (next_state == fbod_pkg::ST_WR) || (next_state == fbod_pkg::ST_WHOLD);
    end
  end
  // the strobe rises at entry to the hold, so data stays stable past it
  assign busy_wr = (state == fbod_pkg::ST_WHOLD);
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      req_ready <= 1'b0;
      aborted   <= 1'b0;
      unprotect_active <= 1'b0;
    end else begin
      rsp_valid <= ((state == fbod_pkg::ST_RD) && cnt_done) || (busy_wr && cnt_done);
      if ((state == fbod_pkg::ST_RD) && cnt_done) begin
        rsp_rdata <= data_in;
      end
      req_ready <= (next_state == fbod_pkg::ST_IDLE);
      // a host-issued reset cuts any device operation short; flag it for a retry
      if (take && req_op == fbod_pkg::OP_RESET) begin
        aborted <= 1'b1;
      end else if (take) begin
        aborted <= 1'b0;
      end
      unprotect_active <= (next_state == fbod_pkg::ST_UNPR);
    end
  end
  fbod_sector_map u_map (
    .mclk      (mclk),
    .srst      (srst),
    .top_boot  (top_boot),
    .sect_bits (req_addr[`FBOD_SECT_LSB +: `FBOD_SECT_W]),
    .sector    (rsp_sector)
  );
endmodule : fbod_host

/* rtl/fbod_pkg.sv */
// Purpose: types for the flash bus host controller
// Assumes: nothing beyond the constants header
// Notes: states one-hot
package fbod_pkg;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_RSET  = 7'h02,
    ST_RD    = 7'h04,
    ST_WR    = 7'h08,
    ST_WHOLD = 7'h10,
    ST_RECOV = 7'h20,
    ST_UNPR  = 7'h40
  } fbod_state_type;
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_RESET = 2'h2,
    OP_UNPR  = 2'h3
  } fbod_op_type;
endpackage : fbod_pkg

/* rtl/fbod_regs.svh */
// Purpose: constants for the flash bus host controller
// Assumes: 40 MHz mclk, 25 ns period
// Notes: pin timing figures are plain defaults; device timing tables are not at hand
// Behaviour
// - read drives chip select and output gate low, write strobe high; device returns byte.
// - write drives write strobe and chip select low with output gate high.
// - host keeps write strobe high throughout every read.
// - reset held low for minimum pulse aborts operation, floats outputs, ignores access.
// - host restarts an operation cut short by hardware reset once device accepts commands; this host restarts nothing and only sets aborted.
`ifndef FBOD_REGS_SVH
`define FBOD_REGS_SVH
`define FBOD_CLK_PERIOD_NS 25
`define FBOD_T_ACC_NS      55
`define FBOD_T_WP_NS       35
`define FBOD_T_SETUP_NS    25
`define FBOD_T_RP_NS       500
`define FBOD_T_READY_NS    20000
`define FBOD_CYC_MIN(ns) (((ns) + `FBOD_CLK_PERIOD_NS - 1) / `FBOD_CLK_PERIOD_NS)
`define FBOD_ADDR_W 17
`define FBOD_SECT_LSB 12
`define FBOD_SECT_W 5
`endif

/* rtl/fbod_sector_map.sv */
// Purpose: maps an address to its sector number for either boot layout
// Assumes: top_boot selects the layout
// Notes: registered output to keep host outputs flop-driven
`timescale 1ns/1ps
`include "fbod_regs.svh"
module fbod_sector_map (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     top_boot,
  input  wire logic [`FBOD_SECT_W-1:0]  sect_bits,
  output logic      [2:0]               sector
);
  logic [2:0] top_sect;
  logic [2:0] bot_sect;
  // only bits 16..12 take part; lower bits never reach here
  assign top_sect = (sect_bits[4:3] != 2'h3) ? {1'b0, sect_bits[4:3]} :
                    (!sect_bits[2])          ? 3'h3 :
                    (!sect_bits[1])          ? (sect_bits[0] ? 3'h5 : 3'h4) :
                                               3'h6;
  assign bot_sect = (sect_bits[4:3] != 2'h0) ? 3'h3 + {1'b0, sect_bits[4:3]} :
                    sect_bits[2]             ? 3'h3 :
                    !sect_bits[1]            ? 3'h0 :
                    (sect_bits[0] ? 3'h2 : 3'h1);
  always_ff @(posedge mclk) begin
    if (srst) begin
      sector <= 3'h0;
    end else begin
      sector <= top_boot ? top_sect : bot_sect;
    end
  end
endmodule : fbod_sector_map

/* tb/fbod_flash_model.sv */
// Purpose: behavioural flash device on the far side of the host
// Assumes: array preloaded with a pattern the bench can predict
// Notes: writes store bytes directly; command decoding is left out
`timescale 1ns/1ps
module fbod_flash_model (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic [16:0] a,
  input  wire logic [7:0]  d,
  output logic      [7:0]  q,
  output logic             q_en
);
  logic [7:0]  mem [0:131071];
  logic [16:0] a_lat;
  assign q_en = !ce_n && !oe_n && we_n && rst_n;
  // no command decoding here, so the array is the only read source in every mode
  assign q    = mem[a];
  initial for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h5a;
  always @(negedge (ce_n | we_n)) a_lat = a;
  // store only when the cycle is a real write, never while reset is low
  // each write completes at once, so a later deselect cannot cut it short; a write
  // stands for a one-byte erase or program, and no sequence is checked for order
  always @(posedge (ce_n | we_n)) if (rst_n && oe_n) mem[a_lat] = d;
endmodule : fbod_flash_model

/* tb/fbod_host_assertions.sv */
// Purpose: pin and handshake checks on the flash host
// Assumes: one clock domain
// Notes: sector mapping is checked by the bench
`timescale 1ns/1ps
module fbod_host_assertions #(
  parameter int RESET_HOLD_CYC = 20,
  parameter int ACC_CYC        = 3,
  parameter int WP_CYC         = 2,
  parameter int SETUP_CYC      = 1
) (
  input wire logic                  mclk,
  input wire logic                  srst,
  input wire logic                  req_valid,
  input wire fbod_pkg::fbod_op_type req_op,
  input wire logic                  req_ready,
  input wire logic                  rsp_valid,
  input wire logic                  unprotect_active,
  input wire logic                  chip_sel_n,
  input wire logic                  out_gate_n,
  input wire logic                  wr_strobe_n,
  input wire logic                  hw_reset_n,
  input wire logic                  data_oe
);
  localparam int RD_LAT  = ACC_CYC + 2;
  localparam int WR_LAT  = WP_CYC + SETUP_CYC + 1;
  localparam int HOLD_M1 = RESET_HOLD_CYC - 1;
  wire take = req_valid && req_ready;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  chk_read_latency:
    assert property (take && req_op == fbod_pkg::OP_READ |-> ##RD_LAT rsp_valid) else $error("read late");
  chk_write_latency:
    assert property (take && req_op == fbod_pkg::OP_WRITE |-> ##WR_LAT rsp_valid) else $error("write late");
  chk_read_levels:
    assert property (!out_gate_n |-> wr_strobe_n && !chip_sel_n && !data_oe) else $error("bad read pins");
  chk_write_levels:
    assert property (!wr_strobe_n |-> !chip_sel_n && out_gate_n && data_oe) else $error("bad write pins");
  chk_reset_pulse:
    assert property ($fell(hw_reset_n) |-> ##HOLD_M1 !hw_reset_n) else $error("reset pulse short");
  chk_reset_quiet:
    assert property (!hw_reset_n |-> chip_sel_n && !data_oe) else $error("access during reset");
  chk_unpr_level:
    assert property (unprotect_active |-> hw_reset_n) else $error("reset low in unprotect");
  chk_idle_deselect:
    assert property (req_ready |-> chip_sel_n && !data_oe) else $error("idle not deselected");
endmodule : fbod_host_assertions
bind fbod_host fbod_host_assertions #(.RESET_HOLD_CYC(RESET_HOLD_CYC), .ACC_CYC(ACC_CYC),
  .WP_CYC(WP_CYC), .SETUP_CYC(SETUP_CYC)) fbod_host_assertions_inst (.mclk, .srst, .req_valid,
  .req_op, .req_ready, .rsp_valid, .unprotect_active, .chip_sel_n, .out_gate_n, .wr_strobe_n,
  .hw_reset_n, .data_oe);

/* tb/flash_bus_operation_decoder_test.sv */
// Purpose: self-checking bench for the flash host
// Assumes: shortened reset and recovery counts
// Notes: expected bytes come from a shadow of the preloaded pattern
`timescale 1ns/1ps
module flash_bus_operation_decoder_test;
  logic mclk = 1'h0, srst = 1'h1, req_valid = 1'h0, top_boot = 1'h0, unprotect_exit = 1'h0;
  fbod_pkg::fbod_op_type req_op = fbod_pkg::OP_READ;
  logic [16:0] req_addr = 17'h0, a;
  logic [7:0]  req_wdata = 8'h0, last = 8'h0, d, shadow [int];
  wire  req_ready, rsp_valid, aborted, unprotect_active, chip_sel_n, out_gate_n, wr_strobe_n;
  wire  hw_reset_n, data_oe, q_en;
  wire  [7:0] rsp_rdata, data_out, q, data_in;
  wire  [2:0] rsp_sector;
  wire  [16:0] addr;
  int   err_count = 0, total_checks = 0, cyc = 0;
  // a released bus shows the inverse of its last level, never a stale copy
  assign data_in = data_oe ? data_out : q_en ? q : ~last;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) last <= data_in;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results;
    end
  end
  fbod_host #(.RESET_HOLD_CYC(2), .READY_CYC(4)) fbod_host_inst (.mclk, .srst, .req_valid,
    .req_op, .req_addr, .req_wdata, .top_boot, .unprotect_exit, .req_ready, .rsp_valid,
    .rsp_rdata, .rsp_sector, .aborted, .unprotect_active, .chip_sel_n, .out_gate_n,
    .wr_strobe_n, .hw_reset_n, .addr, .data_out, .data_oe, .data_in);
  fbod_flash_model fbod_flash_model_inst (.ce_n(chip_sel_n), .oe_n(out_gate_n),
    .we_n(wr_strobe_n), .rst_n(hw_reset_n), .a(addr), .d(data_in), .q, .q_en);
  function automatic logic [7:0] exp_byte(logic [16:0] x);
    return shadow.exists(x) ? shadow[x] : x[7:0] ^ 8'h5a;
  endfunction : exp_byte
  function automatic logic [2:0] sect(logic [4:0] b, logic t);
    if (t) return b[4:3] != 2'h3 ? {1'h0, b[4:3]} : !b[2] ? 3'h3 : !b[1] ? {2'h2, b[0]} : 3'h6;
    return b[4:3] != 2'h0 ? 3'h3 + b[4:3] : b[2] ? 3'h3 : b[1] ? 3'h1 + b[0] : 3'h0;
  endfunction : sect
  task automatic check(logic [16:0] seen, logic [16:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_ready;
    for (int n = 0; n < 3000 && req_ready !== 1'h1; n++) @(negedge mclk);
  endtask : wait_ready
  task automatic run(fbod_pkg::fbod_op_type op, logic [16:0] x, logic [7:0] v);
    req_op = op;
    req_addr = x;
    req_wdata = v;
    req_valid = 1'h1;
    @(negedge mclk);
    req_valid = 1'h0;
    if (op == fbod_pkg::OP_READ || op == fbod_pkg::OP_WRITE)
      for (int n = 0; n < 3000 && rsp_valid !== 1'h1; n++) @(negedge mclk);
    if (op != fbod_pkg::OP_UNPR) wait_ready;
  endtask : run
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    void'($urandom(13));
    repeat (20) @(negedge mclk);
    srst = 1'h0;
    wait_ready;
    for (int i = 0; i < 8; i++) begin
      a = i == 0 ? 17'h0 : i == 1 ? 17'h1ffff : 17'($urandom);
      d = 8'($urandom);
      run(fbod_pkg::OP_WRITE, a, d);
      shadow[a] = d;
      run(fbod_pkg::OP_READ, a, 8'h0);
      check(rsp_rdata, d);
      run(fbod_pkg::OP_READ, a ^ 17'h1, 8'h0);
      check(rsp_rdata, exp_byte(a ^ 17'h1));
    end
    run(fbod_pkg::OP_RESET, 17'h0, 8'h0);
    check(aborted, 1'h1);
    run(fbod_pkg::OP_READ, a, 8'h0);
    check(rsp_rdata, exp_byte(a));
    check(aborted, 1'h0);
    for (int i = 0; i < 64; i++) begin
      top_boot = i[5];
      req_addr = {i[4:0], 12'($urandom)};
      repeat (2) @(negedge mclk);
      check(rsp_sector, sect(i[4:0], i[5]));
    end
    run(fbod_pkg::OP_UNPR, 17'h0, 8'h0);
    @(negedge mclk);
    check(unprotect_active, 1'h1);
    check(hw_reset_n, 1'h1);
    unprotect_exit = 1'h1;
    wait_ready;
    unprotect_exit = 1'h0;
    check(unprotect_active, 1'h0);
    results;
  end
endmodule : flash_bus_operation_decoder_test
